// ===== flash_cfg_pkg.sv
// constants for the serial flash boot, bank, ecc and protection register group
package flash_cfg_pkg;
    // command codes
    localparam logic [7:0] boot_cfg_read_cmd           = 8'h14;
    localparam logic [7:0] boot_cfg_write_cmd          = 8'h15;
    localparam logic [7:0] bank_access_cmd             = 8'hb9;
    localparam logic [7:0] bank_read_cmd               = 8'h16;
    localparam logic [7:0] bank_write_cmd              = 8'h17;
    localparam logic [7:0] register_write_cmd          = 8'h01;
    localparam logic [7:0] ecc_status_read_cmd         = 8'h18;
    localparam logic [7:0] protection_mode_read_cmd    = 8'h2b;
    localparam logic [7:0] protection_mode_program_cmd = 8'h2f;
    localparam logic [7:0] password_read_cmd           = 8'he7;
    localparam logic [7:0] password_program_cmd        = 8'he8;
    // field layout
    localparam int BOOT_W        = 32;
    localparam int BOOT_ADDR_LSB = 9;
    localparam int BOOT_DLY_MSB  = 8;
    localparam int BOOT_DLY_LSB  = 1;
    localparam int BOOT_EN_BIT   = 0;
    localparam int BANK_W        = 8;
    localparam int EXT_BIT       = 7;
    localparam int BANK_HI_BIT   = 1;
    localparam int BANK_LO_BIT   = 0;
    localparam int LEGACY_MSB    = 23;
    localparam int ECC_W         = 8;
    localparam int ECC_FLAGS     = 3;
    localparam int ECC_UNIT_LSB  = 4;
    localparam int PROT_W        = 16;
    localparam int PWD_LOCK_BIT  = 2;
    localparam int PST_LOCK_BIT  = 1;
    localparam int PASS_W        = 64;
    localparam int SHIFT_W       = 64;
    localparam int CNT_W         = 7;
    // phase lengths in serial clock bits
    localparam logic [CNT_W-1:0] CMD_BITS    = 7'h08;
    localparam logic [CNT_W-1:0] ADDR3_BITS  = 7'h18;
    localparam logic [CNT_W-1:0] ADDR4_BITS  = 7'h20;
    localparam logic [CNT_W-1:0] BOOT_BITS   = 7'h20;
    localparam logic [CNT_W-1:0] BANK_BITS   = 7'h08;
    localparam logic [CNT_W-1:0] PROT_BITS   = 7'h10;
    localparam logic [CNT_W-1:0] PASS_BITS   = 7'h40;
    // reset and delivery values
    localparam logic [BOOT_W-1:0] BOOT_RST   = 32'h0000_0000;
    localparam logic [BANK_W-1:0] BANK_RST   = 8'h00;
    localparam logic [BANK_W-1:0] BANK_WMASK = 8'h83;
    localparam logic [PROT_W-1:0] PROT_RST   = 16'hffff;
    localparam logic [PASS_W-1:0] PASS_RST   = 64'hffff_ffff_ffff_ffff;
    localparam logic [PASS_W-1:0] PASS_HIDE  = 64'hffff_ffff_ffff_ffff;
    // command sequencer states, gray along command, address, data
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_CMD   = 3'h1,
        ST_ADDR  = 3'h3,
        ST_ECCLD = 3'h2,
        ST_RD    = 3'h6,
        ST_WR    = 3'h7,
        ST_DONE  = 3'h5
    } seq_state_t;
endpackage

// ===== flash_cfg_regs.sv
// serial command decoder and boot, bank, ecc, protection and password registers
// How it works
// - boot register bits 31..9 hold a nonvolatile 512-byte aligned boot start address.
// - boot register bits 8..1 give delay cycles from select low to first bit.
// - boot register bit 0 enables automatic boot, nonvolatile, defaults off.
// - with boot enabled, a software reset starts an automatic boot read; system reset clears the enable, so it starts none.
// - command 14h reads the boot register, 15h writes it.
// - with extended addressing off, three-byte addresses take upper bits from bank register.
// - with extended addressing on, four full address bytes are used, bank ignored.
// - extended addressing is bank bit 7, volatile, cleared by every reset.
// - bank bits 1 and 0 supply A25 and A24; bits 6..2 reserved.
// - bank register reached by B9h then 01h, read 16h, write 17h.
// - command 18h plus unit address returns that unit's eight-bit ecc status.
// - each ecc unit covers sixteen data bytes with single-bit correction.
// - status bit 2 check-code error, bit 1 data corrected, bit 0 ecc off.
// - protection mode register is 16-bit one-time, read 2Bh, programmed 2Fh.
// - programming protection bit 2 to zero selects password mode for good.
// - programming protection bit 1 to zero selects persistent mode for good.
// - password register holds 64 one-time bits, read E7h, programmed E8h.
// - once password mode is selected, password reads no longer return it.
`timescale 1ns/10ps
`default_nettype none
module flash_cfg_regs
    import flash_cfg_pkg::*;
(
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  soft_rst,
    // serial pins
    input  wire logic                  sck_pin,
    input  wire logic                  cs_n_pin,
    input  wire logic                  mosi_pin,
    output logic                       miso_out,
    output logic                       miso_oe_n,
    // address forming for array commands
    input  wire logic [31:0]           cmd_addr_in,
    output logic [31:0]                array_addr,
    output logic                       extended_addressing,
    output logic                       bank_bit_hi,
    output logic                       bank_bit_lo,
    // ecc unit lookup
    output logic [31-ECC_UNIT_LSB:0]   ecc_unit_addr,
    input  wire logic [ECC_FLAGS-1:0]  ecc_status_in,
    // boot and protection state
    output logic                       boot_req,
    output logic [31:0]                boot_start_address,
    output logic [7:0]                 boot_start_delay,
    output logic                       boot_enable,
    output logic                       password_mode_lock,
    output logic                       persistent_mode_lock
);
    logic                     sck_rise;
    logic                     sck_fall;
    logic                     cs_n_s;
    logic                     cs_fall;
    logic                     mosi_s;
    seq_state_t               state_q;
    seq_state_t               state_d;
    logic [CNT_W-1:0]         cnt_q;
    logic [CNT_W-1:0]         cnt_d;
    logic [CNT_W-1:0]         len_q;
    logic [CNT_W-1:0]         len_d;
    logic [7:0]               cmd_q;
    logic [7:0]               cmd_d;
    logic [SHIFT_W-1:0]       shin_q;
    logic [SHIFT_W-1:0]       shin_d;
    logic [SHIFT_W-1:0]       shin_nx;
    logic [SHIFT_W-1:0]       shout_q;
    logic [SHIFT_W-1:0]       shout_d;
    logic                     miso_q;
    logic                     miso_d;
    logic                     oe_n_q;
    logic                     oe_n_d;
    logic                     arm_q;
    logic                     arm_d;
    logic [BOOT_W-1:0]        boot_q;
    logic [BOOT_W-1:0]        boot_d;
    logic [BANK_W-1:0]        bank_q;
    logic [BANK_W-1:0]        bank_d;
    logic [PROT_W-1:0]        prot_q;
    logic [PROT_W-1:0]        prot_d;
    logic [PASS_W-1:0]        pass_q;
    logic [PASS_W-1:0]        pass_d;
    logic [31-ECC_UNIT_LSB:0] ecc_addr_q;
    logic [31-ECC_UNIT_LSB:0] ecc_addr_d;
    logic                     boot_req_q;
    logic                     boot_req_d;
    logic                     rst_seen_q;
    logic                     rst_seen_d;

    // full byte address from a command address and the bank register
    function automatic logic [31:0] form_addr(input logic [BANK_W-1:0] bank,
                                              input logic [31:0] addr);
        logic [31:0] full;
        full = addr;
        if (!bank[EXT_BIT]) begin
            full = {6'h00, bank[BANK_HI_BIT], bank[BANK_LO_BIT], addr[LEGACY_MSB:0]};
        end
        return full;
    endfunction

    // pin synchronisers
    spi_pin_sync spi_pin_sync_inst (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .sck_pin  (sck_pin),
        .cs_n_pin (cs_n_pin),
        .mosi_pin (mosi_pin),
        .sck_rise (sck_rise),
        .sck_fall (sck_fall),
        .cs_n_s   (cs_n_s),
        .cs_fall  (cs_fall),
        .mosi_s   (mosi_s)
    );

    // command sequencer and register updates
    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        len_d      = len_q;
        cmd_d      = cmd_q;
        shin_d     = shin_q;
        shout_d    = shout_q;
        miso_d     = miso_q;
        oe_n_d     = oe_n_q;
        arm_d      = arm_q;
        boot_d     = boot_q;
        bank_d     = bank_q;
        prot_d     = prot_q;
        pass_d     = pass_q;
        ecc_addr_d = ecc_addr_q;
        boot_req_d = rst_seen_q & boot_q[BOOT_EN_BIT];
        rst_seen_d = 1'b0;
        shin_nx    = {shin_q[SHIFT_W-2:0], mosi_s};
        if (cs_n_s) begin
            state_d = ST_IDLE;
            oe_n_d  = 1'b1;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (cs_fall) begin
                        state_d = ST_CMD;
                        cnt_d   = '0;
                    end
                end
                ST_CMD: begin
                    if (sck_rise) begin
                        shin_d = shin_nx;
                        cnt_d  = cnt_q + 7'h01;
                        if (cnt_q == CMD_BITS - 7'h01) begin
                            cmd_d   = shin_nx[7:0];
                            cnt_d   = '0;
                            arm_d   = 1'b0;
                            state_d = ST_WR;
                            unique case (shin_nx[7:0])
                                boot_cfg_read_cmd: begin
                                    shout_d = {boot_q, 32'h0000_0000};
                                    state_d = ST_RD;
                                end
                                bank_read_cmd: begin
                                    shout_d = {bank_q, 56'h00_0000_0000_0000};
                                    state_d = ST_RD;
                                end
                                protection_mode_read_cmd: begin
                                    shout_d = {prot_q, 48'h0000_0000_0000};
                                    state_d = ST_RD;
                                end
                                password_read_cmd: begin
                                    shout_d = prot_q[PWD_LOCK_BIT] ? pass_q : PASS_HIDE;
                                    state_d = ST_RD;
                                end
                                boot_cfg_write_cmd:          len_d = BOOT_BITS;
                                bank_write_cmd:              len_d = BANK_BITS;
                                protection_mode_program_cmd: len_d = PROT_BITS;
                                password_program_cmd:        len_d = PASS_BITS;
                                register_write_cmd: begin
                                    len_d   = BANK_BITS;
                                    state_d = arm_q ? ST_WR : ST_DONE;
                                end
                                bank_access_cmd: begin
                                    arm_d   = 1'b1;
                                    state_d = ST_DONE;
                                end
                                ecc_status_read_cmd: begin
                                    len_d   = bank_q[EXT_BIT] ? ADDR4_BITS : ADDR3_BITS;
                                    state_d = ST_ADDR;
                                end
                                default: state_d = ST_DONE;
                            endcase
                        end
                    end
                end
                ST_ADDR: begin
                    if (sck_rise) begin
                        shin_d = shin_nx;
                        cnt_d  = cnt_q + 7'h01;
                        if (cnt_q == len_q - 7'h01) begin
                            ecc_addr_d = 28'(form_addr(bank_q, shin_nx[31:0]) >> ECC_UNIT_LSB);
                            state_d    = ST_ECCLD;
                        end
                    end
                end
                ST_ECCLD: begin
                    shout_d = {5'h00, ecc_status_in, 56'h00_0000_0000_0000};
                    state_d = ST_RD;
                end
                ST_RD: begin
                    if (sck_fall) begin
                        miso_d  = shout_q[SHIFT_W-1];
                        shout_d = {shout_q[SHIFT_W-2:0], 1'b0};
                        oe_n_d  = 1'b0;
                    end
                end
                ST_WR: begin
                    if (sck_rise) begin
                        shin_d = shin_nx;
                        cnt_d  = cnt_q + 7'h01;
                        if (cnt_q == len_q - 7'h01) begin
                            state_d = ST_DONE;
                            unique case (cmd_q)
                                boot_cfg_write_cmd:
                                    boot_d = shin_nx[BOOT_W-1:0];
                                bank_write_cmd, register_write_cmd:
                                    bank_d = shin_nx[BANK_W-1:0] & BANK_WMASK;
                                protection_mode_program_cmd:
                                    prot_d = prot_q & shin_nx[PROT_W-1:0];
                                password_program_cmd:
                                    pass_d = pass_q & shin_nx;
                                default: state_d = ST_DONE;
                            endcase
                        end
                    end
                end
                ST_DONE: state_d = ST_DONE;
                default: state_d = ST_IDLE;
            endcase
        end
        if (soft_rst) begin
            bank_d     = BANK_RST;
            rst_seen_d = 1'b1;
        end
    end

    // state registers; nonvolatile values take delivery state at power-on
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q    <= ST_IDLE;
            cnt_q      <= '0;
            len_q      <= '0;
            cmd_q      <= 8'h00;
            shin_q     <= '0;
            shout_q    <= '0;
            miso_q     <= 1'b0;
            oe_n_q     <= 1'b1;
            arm_q      <= 1'b0;
            boot_q     <= BOOT_RST;
            bank_q     <= BANK_RST;
            prot_q     <= PROT_RST;
            pass_q     <= PASS_RST;
            ecc_addr_q <= '0;
            boot_req_q <= 1'b0;
            rst_seen_q <= 1'b1;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            len_q      <= len_d;
            cmd_q      <= cmd_d;
            shin_q     <= shin_d;
            shout_q    <= shout_d;
            miso_q     <= miso_d;
            oe_n_q     <= oe_n_d;
            arm_q      <= arm_d;
            boot_q     <= boot_d;
            bank_q     <= bank_d;
            prot_q     <= prot_d;
            pass_q     <= pass_d;
            ecc_addr_q <= ecc_addr_d;
            boot_req_q <= boot_req_d;
            rst_seen_q <= rst_seen_d;
        end
    end

    // outputs
    assign miso_out             = miso_q;
    assign miso_oe_n            = oe_n_q;
    assign array_addr           = form_addr(bank_q, cmd_addr_in);
    assign extended_addressing  = bank_q[EXT_BIT];
    assign bank_bit_hi          = bank_q[BANK_HI_BIT];
    assign bank_bit_lo          = bank_q[BANK_LO_BIT];
    assign ecc_unit_addr        = ecc_addr_q;
    assign boot_req             = boot_req_q;
    assign boot_start_address   = {boot_q[BOOT_W-1:BOOT_ADDR_LSB], 9'h000};
    assign boot_start_delay     = boot_q[BOOT_DLY_MSB:BOOT_DLY_LSB];
    assign boot_enable          = boot_q[BOOT_EN_BIT];
    assign password_mode_lock   = ~prot_q[PWD_LOCK_BIT];
    assign persistent_mode_lock = ~prot_q[PST_LOCK_BIT];

    // checks
    AST_BOOT_REQ: assert property (@(posedge sys_clk) disable iff (sys_rst)
        boot_req |-> boot_q[BOOT_EN_BIT] && $past(rst_seen_q))
        else $error("boot request without enable or reset");
    AST_SOFT_BANK: assert property (@(posedge sys_clk) disable iff (sys_rst)
        soft_rst |=> bank_q == BANK_RST)
        else $error("bank register not cleared by soft reset");
    AST_PROT_OTP: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (prot_q & ~$past(prot_q)) == '0)
        else $error("protection bit returned to one");
    AST_PASS_OTP: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pass_q & ~$past(pass_q)) == '0)
        else $error("password bit returned to one");
    AST_BANK_FORM: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !bank_q[EXT_BIT] |-> array_addr == {6'h00, bank_q[1:0], cmd_addr_in[23:0]})
        else $error("legacy address not extended by bank");
    AST_EXT_FORM: assert property (@(posedge sys_clk) disable iff (sys_rst)
        bank_q[EXT_BIT] |-> array_addr == cmd_addr_in)
        else $error("four-byte address altered");
    AST_ECC_LOAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == ST_ECCLD && !cs_n_s) |=>
        shout_q[63:56] == {5'h00, $past(ecc_status_in)} && state_q == ST_RD)
        else $error("ecc status not loaded");
    AST_PASS_HIDE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_q == ST_CMD && state_d == ST_RD && cmd_d == password_read_cmd
         && !prot_q[PWD_LOCK_BIT]) |=> shout_q == PASS_HIDE)
        else $error("password exposed in password mode");
    AST_OE_IDLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cs_n_s |=> miso_oe_n)
        else $error("output driven while deselected");
    AST_RESV_BANK: assert property (@(posedge sys_clk) disable iff (sys_rst)
        bank_q[6:2] == 5'h00)
        else $error("reserved bank bits set");
endmodule
`default_nettype wire

// ===== flash_cfg_regs_tb.sv
// self-checking bench for the serial flash configuration register group
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module flash_cfg_regs_tb
    import flash_cfg_pkg::*;
;
    logic        sys_clk, sys_rst, soft_rst, sck_pin, cs_n_pin, mosi_pin;
    logic        miso_out, miso_oe_n, extended_addressing, bank_bit_hi, bank_bit_lo;
    logic        boot_req, boot_enable, password_mode_lock, persistent_mode_lock, seen;
    logic [31:0] cmd_addr_in, array_addr, boot_start_address;
    logic [27:0] ecc_unit_addr;
    logic [2:0]  ecc_status_in;
    logic [7:0]  boot_start_delay;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    flash_cfg_regs flash_cfg_regs_inst (.sys_clk, .sys_rst, .soft_rst, .sck_pin, .cs_n_pin,
        .mosi_pin, .miso_out, .miso_oe_n, .cmd_addr_in, .array_addr, .extended_addressing,
        .bank_bit_hi, .bank_bit_lo, .ecc_unit_addr, .ecc_status_in, .boot_req,
        .boot_start_address, .boot_start_delay, .boot_enable, .password_mode_lock,
        .persistent_mode_lock);
    flash_host_model flash_host_model_inst (.sys_clk, .sck_pin, .cs_n_pin, .mosi_pin,
        .miso_out, .miso_oe_n);

    // verdict and end of run
    task automatic end_sim();
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // one frame, read bits compared under a mask
    task automatic go(input logic [7:0] c, input logic [63:0] wd, input int nw, input int nr,
                      input logic [63:0] exp, input logic [63:0] mask);
        logic [63:0] rd;
        flash_host_model_inst.xfer(c, wd, nw, nr, rd);
        if (nr > 0) `CHK(rd & mask, exp)
    endtask

    // system clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            end_sim();
        end
    end

    // main sequence
    initial begin
        sys_rst = 1'b1;
        soft_rst = 1'b0;
        cmd_addr_in = 32'ha5c3_1e77;
        ecc_status_in = 3'h5;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge sys_clk);
        go(boot_cfg_read_cmd, 0, 0, 32, 64'h0, '1);
        go(bank_read_cmd, 0, 0, 8, 64'h0, '1);
        go(protection_mode_read_cmd, 0, 0, 16, 64'hffff, '1);
        go(password_read_cmd, 0, 0, 64, 64'hffff_ffff_ffff_ffff, '1);
        go(boot_cfg_write_cmd, 64'h1234_5a37, 32, 0, 0, 0);
        go(boot_cfg_read_cmd, 0, 0, 32, 64'h1234_5a37, '1);
        `CHK(boot_start_address, 32'h1234_5a00)
        `CHK(boot_start_delay, 8'h1b)
        `CHK(boot_enable, 1'b1)
        // bank register and address forming
        go(bank_write_cmd, 64'hff, 8, 0, 0, 0);
        go(bank_read_cmd, 0, 0, 8, 64'h83, '1);
        `CHK(extended_addressing, 1'b1)
        `CHK(array_addr, 32'ha5c3_1e77)
        go(ecc_status_read_cmd, 64'h0123_4560, 32, 8, 64'h5, 64'h7);
        `CHK(ecc_unit_addr, 28'h012_3456)
        go(bank_write_cmd, 64'h02, 8, 0, 0, 0);
        `CHK(array_addr, 32'h02c3_1e77)
        `CHK({bank_bit_hi, bank_bit_lo}, 2'b10)
        @(posedge sys_clk) ecc_status_in <= 3'h2;
        go(ecc_status_read_cmd, 64'h00_abc0, 24, 8, 64'h2, 64'h7);
        `CHK(ecc_unit_addr, 28'h020_0abc)
        // general write only after the arming frame
        go(bank_access_cmd, 0, 0, 0, 0, 0);
        go(register_write_cmd, 64'h81, 8, 0, 0, 0);
        go(bank_read_cmd, 0, 0, 8, 64'h81, '1);
        go(register_write_cmd, 64'h00, 8, 0, 0, 0);
        go(bank_read_cmd, 0, 0, 8, 64'h81, '1);
        // software reset clears the bank and starts a boot read
        @(posedge sys_clk) soft_rst <= 1'b1;
        @(posedge sys_clk) soft_rst <= 1'b0;
        seen = 1'b0;
        repeat (6) @(negedge sys_clk) seen |= boot_req;
        `CHK(seen, 1'b1)
        `CHK(extended_addressing, 1'b0)
        `CHK(boot_enable, 1'b1)
        go(bank_read_cmd, 0, 0, 8, 64'h0, '1);
        // one-time password and protection mode
        go(password_program_cmd, 64'h0123_4567_89ab_cdef, 64, 0, 0, 0);
        go(password_program_cmd, 64'hffff_ffff_ffff_ffff, 64, 0, 0, 0);
        go(password_read_cmd, 0, 0, 64, 64'h0123_4567_89ab_cdef, '1);
        go(protection_mode_program_cmd, 64'hfffb, 16, 0, 0, 0);
        go(protection_mode_program_cmd, 64'hffff, 16, 0, 0, 0);
        go(protection_mode_read_cmd, 0, 0, 16, 64'hfffb, '1);
        `CHK(password_mode_lock, 1'b1)
        `CHK(persistent_mode_lock, 1'b0)
        go(password_read_cmd, 0, 0, 64, 64'hffff_ffff_ffff_ffff, '1);
        end_sim();
    end
endmodule
`default_nettype wire

// ===== flash_host_model.sv
// host serial controller model that issues flash commands in mode 0
`timescale 1ns/10ps
`default_nettype none
module flash_host_model (
    // clock that paces the serial pin moves
    input  wire logic sys_clk,
    // serial pins
    output logic      sck_pin,
    output logic      cs_n_pin,
    output logic      mosi_pin,
    input  wire logic miso_out,
    input  wire logic miso_oe_n
);
    logic miso_wire;
    // a released data line shows the inverse of the last driven bit
    assign miso_wire = miso_oe_n ? ~miso_out : miso_out;
    // serial clock idles low and stands still between frames
    initial begin
        sck_pin  = 1'b0;
        cs_n_pin = 1'b1;
        mosi_pin = 1'b0;
    end
    // one frame: command byte, nw bits out msb first, then nr bits in;
    // pins move on system clock edges, five edges to each serial clock half
    task automatic xfer(input logic [7:0] cmd, input logic [63:0] wd, input int nw,
                        input int nr, output logic [63:0] rd);
        rd = '0;
        @(posedge sys_clk) cs_n_pin <= 1'b0;
        for (int i = 0; i < 8 + nw + nr; i++) begin
            if (i < 8)
                mosi_pin <= cmd[7-i];
            else if (i < 8 + nw)
                mosi_pin <= wd[nw+7-i];
            else
                mosi_pin <= 1'b0;
            repeat (5) @(posedge sys_clk);
            sck_pin <= 1'b1;
            if (i >= 8 + nw)
                rd = {rd[62:0], miso_wire};
            repeat (5) @(posedge sys_clk);
            sck_pin <= 1'b0;
        end
        repeat (5) @(posedge sys_clk);
        cs_n_pin <= 1'b1;
        mosi_pin <= ~mosi_pin;
        repeat (50) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ===== spi_pin_sync.sv
// two-stage synchronisers and edge detection for the serial pins
`timescale 1ns/10ps
`default_nettype none
module spi_pin_sync (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // raw pins
    input  wire logic sck_pin,
    input  wire logic cs_n_pin,
    input  wire logic mosi_pin,
    // synchronised view
    output logic      sck_rise,
    output logic      sck_fall,
    output logic      cs_n_s,
    output logic      cs_fall,
    output logic      mosi_s
);
    logic [2:0] meta_q;
    logic [2:0] meta_d;
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic [1:0] prev_q;
    logic [1:0] prev_d;

    // next values: first stage feeds only the second
    always_comb begin
        meta_d = {sck_pin, cs_n_pin, mosi_pin};
        sync_d = meta_q;
        prev_d = sync_q[2:1];
    end

    // registers, idle pin levels under reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_q <= 3'h2;
            sync_q <= 3'h2;
            prev_q <= 2'h1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // edges from second and third stages
    assign sck_rise = sync_q[2] & ~prev_q[1];
    assign sck_fall = ~sync_q[2] & prev_q[1];
    assign cs_n_s   = sync_q[1];
    assign cs_fall  = ~sync_q[1] & prev_q[0];
    assign mosi_s   = sync_q[0];
endmodule
`default_nettype wire
